// >>> core/sec_consts.vh
// Constants for the serial EEPROM command controller: offsets, fields, codes and timing.
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH

// ============================================================
// Register byte offsets
`define SEC_OFS_CMD         8'hB0
`define SEC_OFS_DATA        8'hB4
`define SEC_OFS_IRQ_STAT    8'hB8
`define SEC_OFS_IRQ_CLR     8'hBC
`define SEC_OFS_IRQ_EN      8'hC0

// ============================================================
// Command register fields
`define SEC_CMD_BUSY_BIT    31
`define SEC_CMD_CODE_HI     30
`define SEC_CMD_CODE_LO     28
`define SEC_CMD_TMO_BIT     9
`define SEC_CMD_LOADED_BIT  8
`define SEC_CMD_ADDR_HI     7
`define SEC_CMD_ADDR_LO     0

// ============================================================
// Reset values
`define SEC_RST_ADDR        8'h00
`define SEC_RST_DATA        8'h00
`define SEC_RST_IRQ         3'h0

// ============================================================
// Interrupt status bits
`define SEC_IRQ_DONE_BIT    0
`define SEC_IRQ_TMO_BIT     1
`define SEC_IRQ_LOADED_BIT  2

// ============================================================
// Command codes held in the command register
`define SEC_C_READ          3'h0
`define SEC_C_WDIS          3'h1
`define SEC_C_WEN           3'h2
`define SEC_C_WRITE         3'h3
`define SEC_C_WRALL         3'h4
`define SEC_C_ERASE         3'h5
`define SEC_C_CLRALL        3'h6
`define SEC_C_RELOAD        3'h7

// ============================================================
// Serial opcodes and address-field extensions
`define SEC_OP_READ         2'h2
`define SEC_OP_WRITE        2'h1
`define SEC_OP_ERASE        2'h3
`define SEC_OP_EXT          2'h0
`define SEC_EXT_WEN         2'h3
`define SEC_EXT_WDIS        2'h0
`define SEC_EXT_WRALL       2'h1
`define SEC_EXT_CLRALL      2'h2

// ============================================================
// Frame lengths and reload layout
`define SEC_LEN_SHORT       5'd11
`define SEC_LEN_LONG        5'd19
`define SEC_RL_SIG          8'hA5
`define SEC_RL_BYTES        3'd6

// ============================================================
// Timing
`define SEC_TMO_MS          30
`define SEC_CLK_MHZ         200
`define SEC_TMO_CYCLES      (`SEC_TMO_MS * `SEC_CLK_MHZ * 1000)
`define SEC_SK_HALF         20

`endif

// >>> core/sec_ctrl.v
// Serial EEPROM command controller with AHB-Lite register port and interrupt.
//
// Contract
// - No memory response within timeout abandons the command and returns to idle.
// - A timeout sets the command register timeout flag, marking last operation failed.
// - Data line held high without memory: commands finish normally, never time out.
// - In that case busy clears as soon as the serial sequence ends.
// - Line low, memory absent: only write, write-all, erase, erase-all time out.
// - Address-loaded flag sets after successful power-up or reload; writing one clears it.
// - Command register low byte is the memory address, reset zero.
// - Data register low byte holds read or write value; read/write, resets zero.
// - Data register at fixed offset works with command register; upper bits read zero.
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_ctrl #(
  parameter TMO_CYCLES = `SEC_TMO_CYCLES,
  parameter SK_HALF    = `SEC_SK_HALF,
  parameter [7:0] SIG  = `SEC_RL_SIG
) (
  // Clock, reset and enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout_r,
  output reg  [31:0] hrdata_r,
  output reg         hresp_r,
  // Interrupt
  output reg         irq_r,
  // Station address
  output reg  [47:0] mac_addr_r,
  output reg         addr_loaded_r,
  // Serial memory pins
  output wire        eecs,
  output wire        eesk,
  output wire        eedat_out,
  output wire        eedat_oe,
  input  wire        eedat_in
);

  localparam ST_POR  = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_CMD  = 3'd2;
  localparam ST_RSIG = 3'd3;
  localparam ST_RBYT = 3'd4;

  // ============================================================
  // Helpers
  function [2:0] sticky;
    input [2:0] cur;
    input [2:0] set;
    input [2:0] clr;
    begin
      // A set in the same cycle as a clear wins.
      sticky = (cur & ~clr) | set;
    end
  endfunction

  function [18:0] frame;
    input [2:0] code;
    input [7:0] addr;
    input [7:0] data;
    reg   [1:0] op;
    reg   [7:0] a;
    begin
      op = `SEC_OP_EXT;
      a  = addr;
      case (code)
        `SEC_C_READ:   op = `SEC_OP_READ;
        `SEC_C_RELOAD: op = `SEC_OP_READ;
        `SEC_C_WRITE:  op = `SEC_OP_WRITE;
        `SEC_C_ERASE:  op = `SEC_OP_ERASE;
        `SEC_C_WEN:    a  = {`SEC_EXT_WEN, 6'h00};
        `SEC_C_WDIS:   a  = {`SEC_EXT_WDIS, 6'h00};
        `SEC_C_WRALL:  a  = {`SEC_EXT_WRALL, 6'h00};
        `SEC_C_CLRALL: a  = {`SEC_EXT_CLRALL, 6'h00};
        default:       op = `SEC_OP_EXT;
      endcase
      frame = {1'b1, op, a, data};
    end
  endfunction

  // ============================================================
  // State
  reg  [2:0]  st_r;
  reg         busy_r;
  reg  [2:0]  code_r;
  reg  [7:0]  addr_r;
  reg  [7:0]  data_r;
  reg         tmo_flag_r;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_en_r;
  reg  [2:0]  rl_idx_r;
  reg         ser_start_r;
  reg  [18:0] ser_bits_r;
  reg  [4:0]  ser_len_r;
  reg         ser_rx_r;
  reg         ser_wait_r;
  reg         ap_wr_r;
  reg         ap_rd_r;
  reg  [7:0]  ap_addr_r;
  reg  [2:0]  ev;
  reg  [31:0] rd_mux;
  reg         loaded_set;

  wire        ser_done;
  wire        ser_waiting;
  wire [7:0]  ser_rx;
  wire        tmo_hit;
  wire        ap_take;
  wire        wr_cmd;
  wire        wr_data;
  wire        cmd_go;

  // ============================================================
  // Serial engine and timeout
  sec_serial #(
    .SK_HALF  (SK_HALF)
  ) u_serial (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .start     (ser_start_r),
    .tx_bits   (ser_bits_r),
    .tx_len    (ser_len_r),
    .rx_en     (ser_rx_r),
    .wait_rdy  (ser_wait_r),
    .abort     (tmo_hit),
    .done_r    (ser_done),
    .waiting_r (ser_waiting),
    .rx_byte_r (ser_rx),
    .cs_r      (eecs),
    .sk_r      (eesk),
    .dat_out_r (eedat_out),
    .dat_oe_r  (eedat_oe),
    .dat_in    (eedat_in)
  );

  // Only the ready wait is timed, so commands without a wait cannot time out.
  sec_tmo #(
    .CYCLES    (TMO_CYCLES)
  ) u_tmo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .run       (ser_waiting),
    .expired_r (tmo_hit)
  );

  // ============================================================
  // Bus decode
  assign ap_take = hsel & htrans[1] & hready;
  assign wr_cmd  = ap_wr_r && (ap_addr_r == `SEC_OFS_CMD);
  assign wr_data = ap_wr_r && (ap_addr_r == `SEC_OFS_DATA);
  assign cmd_go  = wr_cmd && !busy_r && hwdata[`SEC_CMD_BUSY_BIT] && (st_r == ST_IDLE);

  always @* begin
    rd_mux = 32'h0000_0000;
    case (ap_addr_r)
      `SEC_OFS_CMD: begin
        rd_mux[`SEC_CMD_BUSY_BIT]                    = busy_r;
        rd_mux[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO]    = code_r;
        rd_mux[`SEC_CMD_TMO_BIT]                     = tmo_flag_r;
        rd_mux[`SEC_CMD_LOADED_BIT]                  = addr_loaded_r;
        rd_mux[`SEC_CMD_ADDR_HI:`SEC_CMD_ADDR_LO]    = addr_r;
      end
      `SEC_OFS_DATA:     rd_mux[7:0] = data_r;
      `SEC_OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_r;
      `SEC_OFS_IRQ_EN:   rd_mux[2:0] = irq_en_r;
      default:           rd_mux      = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // AHB-Lite slave: writes complete with no wait, reads insert one wait state
  // so that a read right after a write sees the new value.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r     <= 1'b0;
      ap_rd_r     <= 1'b0;
      ap_addr_r   <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
      hresp_r     <= 1'b0;
    end else if (ce) begin
      hresp_r <= 1'b0;
      ap_wr_r <= 1'b0;
      if (ap_rd_r) begin
        ap_rd_r     <= 1'b0;
        hrdata_r    <= rd_mux;
        hreadyout_r <= 1'b1;
      end else if (ap_take) begin
        ap_addr_r   <= haddr[7:0];
        ap_wr_r     <= hwrite;
        ap_rd_r     <= ~hwrite;
        hreadyout_r <= hwrite;
      end
    end
  end

  // ============================================================
  // Command sequencer
  always @* begin
    loaded_set = ser_done && (st_r == ST_RBYT) && (rl_idx_r == `SEC_RL_BYTES);
    ev[`SEC_IRQ_DONE_BIT]   = ser_done && (st_r == ST_CMD || loaded_set || (st_r == ST_RSIG && ser_rx != SIG));
    ev[`SEC_IRQ_TMO_BIT]    = tmo_hit;
    ev[`SEC_IRQ_LOADED_BIT] = loaded_set;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= ST_POR;
      busy_r        <= 1'b1;
      code_r        <= `SEC_C_RELOAD;
      addr_r        <= `SEC_RST_ADDR;
      data_r        <= `SEC_RST_DATA;
      tmo_flag_r    <= 1'b0;
      addr_loaded_r <= 1'b0;
      mac_addr_r    <= 48'h0000_0000_0000;
      rl_idx_r      <= 3'd0;
      ser_start_r   <= 1'b0;
      ser_bits_r    <= 19'h00000;
      ser_len_r     <= `SEC_LEN_SHORT;
      ser_rx_r      <= 1'b0;
      ser_wait_r    <= 1'b0;
    end else if (ce) begin
      ser_start_r <= 1'b0;

      // Writing one clears the flag; a set in the same cycle wins.
      if (wr_cmd && hwdata[`SEC_CMD_LOADED_BIT]) begin
        addr_loaded_r <= 1'b0;
      end
      if (loaded_set) begin
        addr_loaded_r <= 1'b1;
      end
      if (wr_cmd && hwdata[`SEC_CMD_TMO_BIT]) begin
        tmo_flag_r <= 1'b0;
      end
      if (tmo_hit) begin
        tmo_flag_r <= 1'b1;
      end

      // The data byte is frozen while a command runs so the frame stays consistent.
      if (wr_data && !busy_r) begin
        data_r <= hwdata[7:0];
      end

      case (st_r)
        ST_POR: begin
          st_r        <= ST_RSIG;
          ser_start_r <= 1'b1;
          ser_bits_r  <= frame(`SEC_C_RELOAD, 8'h00, 8'h00);
          ser_len_r   <= `SEC_LEN_SHORT;
          ser_rx_r    <= 1'b1;
          ser_wait_r  <= 1'b0;
        end
        ST_IDLE: begin
          if (cmd_go) begin
            busy_r      <= 1'b1;
            code_r      <= hwdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO];
            addr_r      <= hwdata[`SEC_CMD_ADDR_HI:`SEC_CMD_ADDR_LO];
            tmo_flag_r  <= 1'b0;
            ser_start_r <= 1'b1;
            ser_bits_r  <= frame(hwdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO],
                                 hwdata[`SEC_CMD_ADDR_HI:`SEC_CMD_ADDR_LO], data_r);
            case (hwdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO])
              `SEC_C_WRITE, `SEC_C_WRALL: begin
                ser_len_r  <= `SEC_LEN_LONG;
                ser_rx_r   <= 1'b0;
                ser_wait_r <= 1'b1;
              end
              `SEC_C_ERASE, `SEC_C_CLRALL: begin
                ser_len_r  <= `SEC_LEN_SHORT;
                ser_rx_r   <= 1'b0;
                ser_wait_r <= 1'b1;
              end
              `SEC_C_READ, `SEC_C_RELOAD: begin
                ser_len_r  <= `SEC_LEN_SHORT;
                ser_rx_r   <= 1'b1;
                ser_wait_r <= 1'b0;
              end
              default: begin
                ser_len_r  <= `SEC_LEN_SHORT;
                ser_rx_r   <= 1'b0;
                ser_wait_r <= 1'b0;
              end
            endcase
            if (hwdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO] == `SEC_C_RELOAD) begin
              st_r <= ST_RSIG;
            end else begin
              st_r <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          // Busy drops a cycle after the sequence or the timeout ends.
          if (ser_done) begin
            busy_r <= 1'b0;
            st_r   <= ST_IDLE;
            if (code_r == `SEC_C_READ) begin
              data_r <= ser_rx;
            end
          end
        end
        ST_RSIG: begin
          if (ser_done) begin
            if (ser_rx == SIG) begin
              st_r        <= ST_RBYT;
              rl_idx_r    <= 3'd1;
              ser_start_r <= 1'b1;
              ser_bits_r  <= frame(`SEC_C_RELOAD, 8'h01, 8'h00);
            end else begin
              // No valid image: the station address stays as it was.
              busy_r <= 1'b0;
              st_r   <= ST_IDLE;
            end
          end
        end
        ST_RBYT: begin
          if (ser_done) begin
            mac_addr_r <= {ser_rx, mac_addr_r[47:8]};
            if (rl_idx_r == `SEC_RL_BYTES) begin
              busy_r <= 1'b0;
              st_r   <= ST_IDLE;
            end else begin
              rl_idx_r    <= rl_idx_r + 3'd1;
              ser_start_r <= 1'b1;
              ser_bits_r  <= frame(`SEC_C_RELOAD, {5'h00, rl_idx_r + 3'd1}, 8'h00);
            end
          end
        end
        default: begin
          st_r   <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Interrupt status, clear and enable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= `SEC_RST_IRQ;
      irq_en_r   <= `SEC_RST_IRQ;
      irq_r      <= 1'b0;
    end else if (ce) begin
      irq_stat_r <= sticky(irq_stat_r, ev,
                           (ap_wr_r && ap_addr_r == `SEC_OFS_IRQ_CLR) ? hwdata[2:0] : 3'h0);
      if (ap_wr_r && ap_addr_r == `SEC_OFS_IRQ_EN) begin
        irq_en_r <= hwdata[2:0];
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

endmodule // sec_ctrl

// >>> core/sec_serial.v
// Serial shift engine: clocks a command frame out, data in, then optionally waits for ready.
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_serial #(
  parameter SK_HALF = `SEC_SK_HALF
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // Request
  input  wire        start,
  input  wire [18:0] tx_bits,
  input  wire [4:0]  tx_len,
  input  wire        rx_en,
  input  wire        wait_rdy,
  input  wire        abort,
  // Answer
  output reg         done_r,
  output reg         waiting_r,
  output reg  [7:0]  rx_byte_r,
  // Memory pins
  output reg         cs_r,
  output reg         sk_r,
  output reg         dat_out_r,
  output reg         dat_oe_r,
  input  wire        dat_in
);

  localparam S_IDLE  = 2'd0;
  localparam S_SHIFT = 2'd1;
  localparam S_GAP   = 2'd2;
  localparam S_WAIT  = 2'd3;

  reg  [1:0]  st_r;
  reg  [15:0] div_r;
  reg  [4:0]  idx_r;
  reg  [4:0]  total_r;
  reg  [4:0]  txn_r;
  reg  [18:0] sh_r;
  reg         wait_r;
  wire        tick;

  assign tick = (div_r == SK_HALF - 1);

  // ============================================================
  // Sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= S_IDLE;
      div_r     <= 16'h0000;
      idx_r     <= 5'd0;
      total_r   <= 5'd0;
      txn_r     <= 5'd0;
      sh_r      <= 19'h00000;
      wait_r    <= 1'b0;
      done_r    <= 1'b0;
      waiting_r <= 1'b0;
      rx_byte_r <= 8'h00;
      cs_r      <= 1'b0;
      sk_r      <= 1'b0;
      dat_out_r <= 1'b0;
      dat_oe_r  <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      div_r  <= (st_r == S_IDLE || tick) ? 16'h0000 : div_r + 16'h0001;
      case (st_r)
        S_IDLE: begin
          if (start) begin
            st_r      <= S_SHIFT;
            cs_r      <= 1'b1;
            sk_r      <= 1'b0;
            dat_oe_r  <= 1'b1;
            dat_out_r <= tx_bits[18];
            sh_r      <= {tx_bits[17:0], 1'b0};
            idx_r     <= 5'd0;
            txn_r     <= tx_len;
            total_r   <= rx_en ? tx_len + 5'd8 : tx_len;
            wait_r    <= wait_rdy;
          end
        end
        S_SHIFT: begin
          if (tick) begin
            if (!sk_r) begin
              sk_r <= 1'b1;
              if (idx_r >= txn_r) begin
                rx_byte_r <= {rx_byte_r[6:0], dat_in};
              end
            end else begin
              sk_r  <= 1'b0;
              idx_r <= idx_r + 5'd1;
              if (idx_r + 5'd1 == total_r) begin
                st_r      <= S_GAP;
                cs_r      <= 1'b0;
                dat_oe_r  <= 1'b0;
                dat_out_r <= 1'b0;
              end else if (idx_r + 5'd1 < txn_r) begin
                dat_out_r <= sh_r[18];
                sh_r      <= {sh_r[17:0], 1'b0};
              end else begin
                dat_oe_r  <= 1'b0;
                dat_out_r <= 1'b0;
              end
            end
          end
        end
        S_GAP: begin
          if (tick) begin
            if (wait_r) begin
              st_r      <= S_WAIT;
              cs_r      <= 1'b1;
              waiting_r <= 1'b1;
            end else begin
              st_r   <= S_IDLE;
              done_r <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          // A line held high with no part fitted reads as ready at once and never times out.
          if (dat_in || abort) begin
            st_r      <= S_IDLE;
            cs_r      <= 1'b0;
            waiting_r <= 1'b0;
            done_r    <= 1'b1;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // sec_serial

// >>> core/sec_tmo.v
// Ready-wait timeout counter for the serial EEPROM controller.
`timescale 1ns/10ps
module sec_tmo #(
  parameter CYCLES = 6000000
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // Control
  input  wire        run,
  output reg         expired_r
);

  reg  [31:0] cnt_r;

  // ============================================================
  // Counter
  // Restarts whenever the wait is idle, so each wait gets the full period.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= 32'h0000_0000;
      expired_r <= 1'b0;
    end else if (ce) begin
      expired_r <= 1'b0;
      if (!run) begin
        cnt_r <= 32'h0000_0000;
      end else if (cnt_r == CYCLES - 1) begin
        cnt_r     <= 32'h0000_0000;
        expired_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end

endmodule // sec_tmo

// >>> dv/sec_ctrl_sva.sv
// Port assertions for the serial EEPROM command controller.
`timescale 1ns/10ps
module sec_ctrl_sva #(
  parameter int TMO_CYCLES = 6000000,
  parameter int SK_HALF    = 20
) (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  input wire        ce,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout_r,
  input wire [31:0] hrdata_r,
  input wire        hresp_r,
  // Flag and memory pins
  input wire        addr_loaded_r,
  input wire        eecs,
  input wire        eesk,
  input wire        eedat_oe,
  input wire        eedat_in
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc = hsel && htrans[1] && hready && ce;
  int  low_r;
  // Cycles in the current stretch with select high, the line released and the clock parked.
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) low_r <= 0;
    else low_r <= (eecs && !eesk && !eedat_oe) ? low_r + 1 : 0;
  AST_TMO_BOUND: assert property (low_r <= TMO_CYCLES + 2 * SK_HALF + 8)
    else $error("ready wait outlived the timeout");
  AST_READY_ENDS: assert property (low_r > 2 * SK_HALF && eedat_in |-> ##[1:3] !eecs)
    else $error("ready seen but select stayed high");
  AST_LOAD_IDLE: assert property ($rose(addr_loaded_r) |-> !eecs)
    else $error("loaded flag rose during a frame");
  AST_LOAD_CLEAR: assert property (acc && hwrite && haddr[7:0] == 8'hB0 ##1 hwdata[8] |-> ##[1:2] !addr_loaded_r)
    else $error("loaded flag not cleared by write");
  AST_RD_WAIT: assert property (acc && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
    else $error("read data phase length wrong");
  AST_WR_ZERO: assert property (acc && hwrite |=> hreadyout_r)
    else $error("write data phase stalled");
  AST_DATA_HI: assert property (acc && !hwrite && haddr[7:0] == 8'hB4 |-> ##2 hrdata_r[31:8] == 24'h0)
    else $error("data register upper bits not zero");
  AST_OKAY: assert property (hresp_r == 1'b0)
    else $error("response not OKAY");
  AST_OE_CS: assert property (eedat_oe |-> eecs)
    else $error("line driven without select");
  AST_CLK_CS: assert property ($rose(eesk) |-> eecs)
    else $error("serial clock outside a frame");
  COV_TMO: cover property (low_r == TMO_CYCLES);
  COV_LOAD: cover property ($rose(addr_loaded_r));
  COV_RD: cover property (acc && !hwrite ##2 hreadyout_r);
endmodule // sec_ctrl_sva
bind sec_ctrl sec_ctrl_sva #(.TMO_CYCLES(TMO_CYCLES), .SK_HALF(SK_HALF)) sec_ctrl_sva_i (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout_r(hreadyout_r), .hrdata_r(hrdata_r), .hresp_r(hresp_r),
  .addr_loaded_r(addr_loaded_r), .eecs(eecs), .eesk(eesk), .eedat_oe(eedat_oe), .eedat_in(eedat_in));

// >>> dv/sec_mem_model.sv
// Behavioural serial EEPROM placed on the controller's memory pins.
`timescale 1ns/10ps
module sec_mem_model #(
  parameter logic [7:0] SIG = 8'hA5
) (
  // Clock and test controls: mode 0 fitted, 1 absent with pull-up, 2 absent with pull-down
  input  wire       hclk,
  input  wire [1:0] mode,
  input  wire [7:0] dly,
  // Memory pins
  input  wire       cs,
  input  wire       sk,
  input  wire       dat_out,
  input  wire       oe,
  output wire       line
);
  logic [7:0]  mem [0:255];
  logic [18:0] sh;
  logic [4:0]  n;
  logic [1:0]  op;
  logic [7:0]  a, cnt;
  logic        en, bo, tog;
  initial begin
    for (int i = 1; i < 256; i++) mem[i] = 8'(i + 16);
    mem[0] = SIG;
    {sh, n, op, a, cnt, en, bo, tog} = '0;
  end
  always @(posedge sk) if (cs) begin
    sh <= {sh[17:0], dat_out};
    n  <= n + 5'h01;
    if (n == 5'h0A) {op, a} <= {sh[8:0], dat_out};
  end
  always @(negedge sk) if (cs && op == 2'h2 && n >= 5'h0B) bo <= mem[a][5'h12 - n];
  // The array powers up protected; only the enable command opens it.
  always @(negedge cs) begin
    if (mode == 2'h0 && n >= 5'h0B) begin
      if (op == 2'h0 && a[7:6] == 2'h3) en <= 1'b1;
      else if (op == 2'h0 && a[7:6] == 2'h0) en <= 1'b0;
      else if (en && op != 2'h2) begin
        cnt <= dly;
        if (op != 2'h0) mem[a] <= op[1] ? 8'hFF : sh[7:0];
        else for (int i = 0; i < 256; i++) mem[i] <= a[7] ? 8'hFF : sh[7:0];
      end
    end
    n <= 5'h00;
  end
  always @(posedge hclk) begin
    tog <= ~tog;
    if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
  // A released line toggles so a stale level never passes as read data.
  assign line = oe ? dat_out : mode == 2'h1 ? 1'b1 : mode == 2'h2 ? 1'b0 : !cs ? tog :
                n == 5'h00 ? cnt == 8'h00 : (op == 2'h2 && n >= 5'h0B) ? bo : tog;
endmodule // sec_mem_model

// >>> dv/tb_sec_ctrl.sv
// Self-checking testbench for the serial EEPROM command controller.
`timescale 1ns/10ps
module tb_sec_ctrl;
  localparam int TMO = 200;
  localparam int SKH = 2;
  localparam int LIM = 19 * 2 * SKH + 2 * SKH + 24;
  logic        hclk, hresetn, ce, hsel, hwrite;
  logic [1:0]  htrans, mode;
  logic [31:0] haddr, hwdata, hrdata_r, q;
  logic [7:0]  dly;
  logic [47:0] mac_addr_r;
  logic        hreadyout_r, hresp_r, irq_r, addr_loaded_r;
  logic        eecs, eesk, eedat_out, eedat_oe, eedat_in;
  int          fail_count, samples_checked, cyc, span;
  sec_ctrl #(.TMO_CYCLES(TMO), .SK_HALF(SKH)) sec_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_r), .hreadyout_r(hreadyout_r), .hrdata_r(hrdata_r),
    .hresp_r(hresp_r), .irq_r(irq_r), .mac_addr_r(mac_addr_r), .addr_loaded_r(addr_loaded_r), .eecs(eecs),
    .eesk(eesk), .eedat_out(eedat_out), .eedat_oe(eedat_oe), .eedat_in(eedat_in));
  sec_mem_model sec_mem_model_i (.hclk(hclk), .mode(mode), .dly(dly), .cs(eecs), .sk(eesk),
    .dat_out(eedat_out), .oe(eedat_oe), .line(eedat_in));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  // ============================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    q = hrdata_r;
  endtask
  task automatic wait_idle;
    int n;
    n = cyc;
    do xfer(1'b0, 8'hB0, 32'h0); while (q[31] !== 1'b0);
    span = cyc - n;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] a);
    xfer(1'b1, 8'hB0, {1'b1, c, 20'h0, a});
    wait_idle;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_power_up;
    xfer(1'b0, 8'hB4, 32'h0);
    chk("data reset", 32'h0, q);
    wait_idle;
    chk("cmd after load", 32'h100, q & 32'h8000_03FF);
    chk("mac low", 32'h1413_1211, mac_addr_r[31:0]);
    chk("mac high", 32'h1615, {16'h0, mac_addr_r[47:32]});
    xfer(1'b1, 8'hB0, 32'h100);
    xfer(1'b0, 8'hB0, 32'h0);
    chk("flag cleared", 32'h0, q & 32'h100);
    $display("test power_up done");
  endtask
  task automatic t_write_read;
    dly = 8'd50;
    cmd(3'h2, 8'hC0);
    xfer(1'b1, 8'hB4, 32'hFFFF_FFC3);
    xfer(1'b0, 8'hB4, 32'h0);
    chk("data rw", 32'hC3, q);
    cmd(3'h3, 8'hFF);
    chk("cmd write", 32'hFF, q & 32'h8000_03FF);
    chk("mem top", 32'hC3, {24'h0, sec_mem_model_i.mem[255]});
    chk("mem next", 32'h0E, {24'h0, sec_mem_model_i.mem[254]});
    xfer(1'b1, 8'hB4, 32'h0);
    cmd(3'h0, 8'hFF);
    xfer(1'b0, 8'hB4, 32'h0);
    chk("data read", 32'hC3, q);
    $display("test write_read done");
  endtask
  // A missing memory: line pulled high (mode 1) or low (mode 2).
  task automatic t_absent(input logic [1:0] m);
    logic to;
    mode = m;
    for (int c = 0; c < 7; c++) begin
      to = m == 2'h2 && c >= 3;
      cmd(3'(c), 8'h10);
      chk("timeout flag", {22'h0, to, 9'h0}, q & 32'h8000_0200);
      chk("busy span", 32'h1, {31'h0, span <= LIM + (to ? TMO : 0) && (!to || span >= TMO)});
    end
    $display("test absent done");
  endtask
  task automatic t_irq;
    xfer(1'b1, 8'hBC, 32'h7);
    xfer(1'b1, 8'hC0, 32'h0);
    cmd(3'h5, 8'h20);
    xfer(1'b0, 8'hB8, 32'h0);
    chk("status", 32'h2, q & 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq_r});
    xfer(1'b1, 8'hC0, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq_r});
    xfer(1'b1, 8'hBC, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq_r});
    xfer(1'b0, 8'hC4, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test irq done");
  endtask
  task automatic t_reload;
    mode = 2'h0;
    sec_mem_model_i.mem[0] = 8'h00;
    cmd(3'h7, 8'h00);
    chk("bad signature", 32'h0, q & 32'h100);
    sec_mem_model_i.mem[0] = 8'hA5;
    cmd(3'h7, 8'h00);
    chk("reloaded", 32'h100, q & 32'h100);
    chk("loaded pin", 32'h1, {31'h0, addr_loaded_r});
    $display("test reload done");
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, cyc, fail_count, samples_checked} = '0;
    ce = 1'b1;
    mode = 2'h0;
    dly = 8'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_power_up;
    t_write_read;
    t_absent(2'h1);
    t_absent(2'h2);
    t_irq;
    t_reload;
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    end_of_test;
  end
endmodule // tb_sec_ctrl
